// ===== ide_host_defines.svh
// Purpose: constants for the parallel disk host port controller
// Assumes: 200 MHz system clock, 5 ns period
// Notes:   timing counts derive from figures in ns
`ifndef IDE_HOST_DEFINES_SVH
`define IDE_HOST_DEFINES_SVH

`define CLK_PERIOD_NS      5
// address and select setup before a strobe falls
`define ADDR_SETUP_NS      70
`define ADDR_SETUP_CYC     ((`ADDR_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// least strobe width
`define STROBE_WIDTH_NS    165
`define STROBE_WIDTH_CYC   ((`STROBE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// hold of address, select and write data after the strobe rises
`define ADDR_HOLD_NS       30
`define ADDR_HOLD_CYC      ((`ADDR_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// reset pulse driven to the device
`define DEV_RESET_NS       1000
`define DEV_RESET_CYC      ((`DEV_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W              8
`define DATA_REG_ADDR      3'h0
`define CTRL_REG_ADDR      3'h6
`define BYTE_MASK          16'h00FF

`endif

// ===== ide_host_pkg.sv
// Purpose: types for the parallel disk host port controller
// Assumes: constants come from ide_host_defines.svh
// Notes:   none
package ide_host_pkg;

  typedef enum logic [1:0] {
    SPACE_TASK_FILE,
    SPACE_CONTROL,
    SPACE_DATA
  } space_t;

  typedef struct packed {
    logic        write;
    space_t      space;
    logic [2:0]  addr;
    logic [15:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic [15:0] rdata;
    logic        word_cycle;
  } host_rsp_t;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } phase_t;

endpackage

// ===== ide_host_port_pins.sv
// Purpose: host controller that runs single accesses on the disk port pins
// Assumes: one request at a time, taken when O_REQ_READY is high
// Notes:   device side pins pass a two-stage synchroniser before use
`timescale 1ns/1ps
`include "ide_host_defines.svh"

module ide_host_port_pins (
  input  wire logic                  I_CLK_SYS,
  input  wire logic                  I_ARST_N,
  input  wire logic                  I_REQ_VALID,
  input  wire ide_host_pkg::host_req_t I_REQ,
  input  wire logic                  I_DEV_RESET,
  input  wire logic                  I_DIAG_PASS,
  output logic                       O_REQ_READY,
  output logic                       O_RSP_VALID,
  output ide_host_pkg::host_rsp_t    O_RSP,
  output logic                       O_RESET_N,
  output logic [2:0]                 O_ADDR,
  output logic                       O_TASK_FILE_SELECT_N,
  output logic                       O_CONTROL_BLOCK_SELECT_N,
  output logic                       O_IO_READ_STROBE_N,
  output logic                       O_IO_WRITE_STROBE_N,
  output logic [15:0]                O_DATA,
  output logic                       O_DATA_OE,
  input  wire logic [15:0]           I_DATA,
  input  wire logic                  I_INTRQ,
  input  wire logic                  I_IO_CHANNEL_READY,
  input  wire logic                  I_WORD_CYCLE_N,
  input  wire logic                  I_PASS_DIAG_N,
  output logic                       O_PASS_DIAG_N,
  output logic                       O_PASS_DIAG_OE,
  input  wire logic                  I_ACTIVITY_PRESENT_N,
  output logic                       O_IRQ,
  output logic                       O_DEVICE_BUSY
);
  import ide_host_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    phase_t           phase;
    logic [`CNT_W-1:0] cnt;
    host_req_t        req;
    logic             req_ready;
    logic             rsp_valid;
    host_rsp_t        rsp;
    logic             reset_n;
    logic [2:0]       addr;
    logic             cs0_n;
    logic             cs1_n;
    logic             rd_n;
    logic             wr_n;
    logic [15:0]      dout;
    logic             doe;
    logic             diag_oe;
    logic [1:0]       irq_sync;
    logic [1:0]       rdy_sync;
    logic [1:0]       w16_sync;
    logic [1:0]       act_sync;
    logic [15:0]      dat_meta;
    logic [15:0]      dat_sync;
    logic             irq;
    logic             busy;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    nxt_st           = st_ff;
    nxt_st.rsp_valid = 1'b0;
    // pin inputs: two flops before use
    nxt_st.irq_sync = {st_ff.irq_sync[0], I_INTRQ};
    nxt_st.rdy_sync = {st_ff.rdy_sync[0], I_IO_CHANNEL_READY};
    nxt_st.w16_sync = {st_ff.w16_sync[0], I_WORD_CYCLE_N};
    nxt_st.act_sync = {st_ff.act_sync[0], I_ACTIVITY_PRESENT_N};
    // data pins too: only the second stage is read
    nxt_st.dat_meta = I_DATA;
    nxt_st.dat_sync = st_ff.dat_meta;
    nxt_st.irq      = st_ff.irq_sync[1];
    nxt_st.busy     = ~st_ff.act_sync[1];
    // open drain: pull low only to report pass
    nxt_st.diag_oe  = I_DIAG_PASS;
    if (I_DEV_RESET && st_ff.phase != ST_RESET)
    begin
      nxt_st.phase     = ST_RESET;
      nxt_st.cnt       = '0;
      nxt_st.req_ready = 1'b0;
      nxt_st.reset_n   = 1'b0;
      nxt_st.cs0_n     = 1'b1;
      nxt_st.cs1_n     = 1'b1;
      nxt_st.rd_n      = 1'b1;
      nxt_st.wr_n      = 1'b1;
      nxt_st.doe       = 1'b0;
    end
    else
    begin
      case (st_ff.phase)
        ST_RESET:
        begin
          if (st_ff.cnt == `CNT_W'(`DEV_RESET_CYC - 1))
          begin
            nxt_st.phase     = ST_IDLE;
            nxt_st.reset_n   = 1'b1;
            nxt_st.req_ready = 1'b1;
            nxt_st.cnt       = '0;
          end
          else
            nxt_st.cnt = st_ff.cnt + `CNT_W'(1);
        end
        ST_IDLE:
        begin
          if (I_REQ_VALID)
          begin
            nxt_st.req       = I_REQ;
            nxt_st.req_ready = 1'b0;
            nxt_st.phase     = ST_SETUP;
            nxt_st.cnt       = '0;
            // only I/O space exists: control block or task file
            if (I_REQ.space == SPACE_CONTROL)
            begin
              nxt_st.cs1_n = 1'b0;
              nxt_st.addr  = `CTRL_REG_ADDR;
            end
            else
            begin
              nxt_st.cs0_n = 1'b0;
              nxt_st.addr  = (I_REQ.space == SPACE_DATA) ? `DATA_REG_ADDR : I_REQ.addr;
            end
            if (I_REQ.write)
            begin
              // byte registers carry data on the low lane only
              nxt_st.dout = (I_REQ.space == SPACE_DATA) ? I_REQ.wdata
                            : (I_REQ.wdata & `BYTE_MASK);
              nxt_st.doe  = 1'b1;
            end
          end
        end
        ST_SETUP:
        begin
          if (st_ff.cnt == `CNT_W'(`ADDR_SETUP_CYC - 1))
          begin
            nxt_st.phase = ST_STROBE;
            nxt_st.cnt   = '0;
            nxt_st.rd_n  = st_ff.req.write;
            nxt_st.wr_n  = ~st_ff.req.write;
          end
          else
            nxt_st.cnt = st_ff.cnt + `CNT_W'(1);
        end
        ST_STROBE:
        begin
          // device may stretch the cycle with its ready line
          if (st_ff.cnt >= `CNT_W'(`STROBE_WIDTH_CYC - 1) && st_ff.rdy_sync[1])
          begin
            nxt_st.phase = ST_HOLD;
            nxt_st.cnt   = '0;
            nxt_st.rd_n  = 1'b1;
            nxt_st.wr_n  = 1'b1;
            if (!st_ff.req.write)
            begin
              // synced copy lags two cycles, bus settled long before strobe end
              nxt_st.rsp.rdata = (st_ff.req.space == SPACE_DATA) ? st_ff.dat_sync
                                 : (st_ff.dat_sync & `BYTE_MASK);
            end
            nxt_st.rsp.word_cycle = ~st_ff.w16_sync[1];
          end
          else if (st_ff.cnt != {`CNT_W{1'b1}})
            nxt_st.cnt = st_ff.cnt + `CNT_W'(1);
        end
        ST_HOLD:
        begin
          if (st_ff.cnt == `CNT_W'(`ADDR_HOLD_CYC - 1))
          begin
            nxt_st.phase     = ST_IDLE;
            nxt_st.cs0_n     = 1'b1;
            nxt_st.cs1_n     = 1'b1;
            nxt_st.doe       = 1'b0;
            nxt_st.rsp_valid = 1'b1;
            nxt_st.req_ready = 1'b1;
            nxt_st.cnt       = '0;
          end
          else
            nxt_st.cnt = st_ff.cnt + `CNT_W'(1);
        end
        default:
          nxt_st.phase = ST_RESET;
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      st_ff         <= '0;
      st_ff.phase   <= ST_RESET;
      st_ff.cs0_n   <= 1'b1;
      st_ff.cs1_n   <= 1'b1;
      st_ff.rd_n    <= 1'b1;
      st_ff.wr_n    <= 1'b1;
      st_ff.rdy_sync <= 2'h3;
      st_ff.w16_sync <= 2'h3;
      st_ff.act_sync <= 2'h3;
    end
    else
      st_ff <= nxt_st;
  end

  assign O_REQ_READY              = st_ff.req_ready;
  assign O_RSP_VALID              = st_ff.rsp_valid;
  assign O_RSP                    = st_ff.rsp;
  assign O_RESET_N                = st_ff.reset_n;
  assign O_ADDR                   = st_ff.addr;
  assign O_TASK_FILE_SELECT_N     = st_ff.cs0_n;
  assign O_CONTROL_BLOCK_SELECT_N = st_ff.cs1_n;
  assign O_IO_READ_STROBE_N       = st_ff.rd_n;
  assign O_IO_WRITE_STROBE_N      = st_ff.wr_n;
  assign O_DATA                   = st_ff.dout;
  assign O_DATA_OE                = st_ff.doe;
  assign O_PASS_DIAG_N            = 1'b0;
  assign O_PASS_DIAG_OE           = st_ff.diag_oe;
  assign O_IRQ                    = st_ff.irq;
  assign O_DEVICE_BUSY            = st_ff.busy;

endmodule

// ===== ide_host_port_pins_properties.sv
// Purpose: pin protocol checks for the disk host port controller
// Assumes: bound to the controller top, one clock domain
// Notes:   none
`timescale 1ns/1ps
module ide_host_port_pins_properties (
  input wire logic        I_CLK_SYS,
  input wire logic        I_ARST_N,
  input wire logic        I_INTRQ,
  input wire logic        I_ACTIVITY_PRESENT_N,
  input wire logic [2:0]  O_ADDR,
  input wire logic        O_TASK_FILE_SELECT_N,
  input wire logic        O_CONTROL_BLOCK_SELECT_N,
  input wire logic        O_IO_READ_STROBE_N,
  input wire logic        O_IO_WRITE_STROBE_N,
  input wire logic [15:0] O_DATA,
  input wire logic        O_DATA_OE,
  input wire logic        O_IRQ,
  input wire logic        O_DEVICE_BUSY
);
  wire rd = !O_IO_READ_STROBE_N;
  wire wr = !O_IO_WRITE_STROBE_N;
  wire tf = !O_TASK_FILE_SELECT_N;
  wire cb = !O_CONTROL_BLOCK_SELECT_N;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_ARST_N);
  a_sel_onehot: assert property ((rd || wr) |-> (tf ^ cb)) else $error("select not one-hot");
  a_ctrl_addr: assert property (cb |-> O_ADDR == 3'h6) else $error("control address");
  a_read_float: assert property (rd |-> !O_DATA_OE) else $error("bus driven in read");
  a_write_hold: assert property ($rose(O_IO_WRITE_STROBE_N) |-> O_DATA_OE && $stable(O_DATA))
    else $error("write data moved");
  a_byte_lane: assert property (wr && tf && O_ADDR != 3'h0 |-> O_DATA[15:8] == 8'h00)
    else $error("upper lane used");
  a_strobe_width: assert property ($fell(O_IO_READ_STROBE_N) |-> rd[*8] ##25 rd) else $error("short read");
  a_irq_follow: assert property ($rose(I_INTRQ) |-> ##[1:4] O_IRQ) else $error("irq lost");
  a_busy_seen: assert property ((!I_ACTIVITY_PRESENT_N)[*4] |-> O_DEVICE_BUSY) else $error("busy lost");
endmodule

bind ide_host_port_pins ide_host_port_pins_properties chk (.*);

// ===== ide_disk_model.sv
// Purpose: behavioural disk module seen from its host pins
// Assumes: clock only paces the float pattern and ready stretch
// Notes:   io space only, no memory window
`timescale 1ns/1ps
module ide_disk_model (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [2:0]  i_a,
  input  wire logic        i_tf_n,
  input  wire logic        i_cb_n,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_slow,
  input  wire logic        i_irq,
  output logic      [15:0] o_dq,
  output logic             o_rdy,
  output logic             o_word_n,
  output logic             o_act_n,
  output logic             o_irq
);
  logic [15:0] regs [8];
  logic [15:0] last = 16'h0000;
  logic [5:0]  wt = 6'h00;
  wire tf = !i_tf_n && i_cb_n;
  wire cb = !i_cb_n && i_tf_n;
  always @(posedge i_wr_n or negedge i_rst_n)
    if (!i_rst_n)
      regs <= '{default: 16'h0000};
    else if (tf)
      regs[i_a] <= (i_a == 3'h0) ? i_dq : {8'h00, i_dq[7:0]};
  always_ff @(posedge i_clk)
  begin
    last <= o_dq;
    wt <= (i_rd_n && i_wr_n) ? 6'h00 : wt + {5'h00, wt != 6'h3F};
  end
  // released bus toggles so a stale value never looks valid
  assign o_dq = (!i_rd_n && (tf || cb)) ? (cb ? {8'h00, regs[7][7:0]} : regs[i_a]) : ~last;
  assign o_rdy = !i_slow || wt > 6'h28;
  assign o_word_n = !(tf && i_a == 3'h0);
  assign o_act_n = i_rd_n && i_wr_n;
  assign o_irq = i_irq && i_rst_n;
endmodule

// ===== ide_host_port_pins_bench.sv
// Purpose: self-checking bench for the disk host port controller
// Assumes: far side is the behavioural disk model
// Notes:   seeded random accesses plus reset, irq and diag corners
`timescale 1ns/1ps
module ide_host_port_pins_bench;
  import ide_host_pkg::*;
  logic I_CLK_SYS = 1'b0, I_ARST_N = 1'b0, I_REQ_VALID = 1'b0, I_DEV_RESET = 1'b0, I_DIAG_PASS = 1'b0;
  logic slow = 1'b0, irq = 1'b0, O_REQ_READY, O_RSP_VALID, O_RESET_N, O_DATA_OE, O_IRQ, O_DEVICE_BUSY;
  logic O_TASK_FILE_SELECT_N, O_CONTROL_BLOCK_SELECT_N, O_IO_READ_STROBE_N, O_IO_WRITE_STROBE_N;
  logic O_PASS_DIAG_N, O_PASS_DIAG_OE, I_INTRQ, I_IO_CHANNEL_READY, I_WORD_CYCLE_N, I_ACTIVITY_PRESENT_N;
  logic I_PASS_DIAG_N;
  logic [2:0] O_ADDR, a;
  logic [15:0] O_DATA, I_DATA, dev_dq, d, exp_q [8] = '{default: 16'h0000};
  host_req_t I_REQ = '0;
  host_rsp_t O_RSP;
  space_t s;
  int error_cnt = 0, comparisons = 0;
  // shared data and diag wires: diag is pulled up
  assign I_DATA = O_DATA_OE ? O_DATA : dev_dq;
  assign I_PASS_DIAG_N = !(O_PASS_DIAG_OE && !O_PASS_DIAG_N);
  ide_host_port_pins uut (.*);
  ide_disk_model dev (.i_clk(I_CLK_SYS), .i_rst_n(O_RESET_N), .i_a(O_ADDR), .i_tf_n(O_TASK_FILE_SELECT_N),
    .i_cb_n(O_CONTROL_BLOCK_SELECT_N), .i_rd_n(O_IO_READ_STROBE_N), .i_wr_n(O_IO_WRITE_STROBE_N),
    .i_dq(I_DATA), .i_slow(slow), .i_irq(irq), .o_dq(dev_dq), .o_rdy(I_IO_CHANNEL_READY),
    .o_word_n(I_WORD_CYCLE_N), .o_act_n(I_ACTIVITY_PRESENT_N), .o_irq(I_INTRQ));
  function automatic logic [15:0] lane(input space_t sp, input logic [15:0] v);
    return (sp == SPACE_DATA) ? v : {8'h00, v[7:0]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one access; the 1 ns lets the taking edge settle
  task automatic xfer(input logic w, input space_t sp, input logic [2:0] ad, input logic [15:0] v);
    #1;
    wait (O_REQ_READY === 1'b1);
    @(posedge I_CLK_SYS);
    I_REQ_VALID <= 1'b1;
    I_REQ <= '{w, sp, ad, v};
    slow <= 1'($urandom);
    @(posedge I_CLK_SYS);
    I_REQ_VALID <= 1'b0;
    @(posedge O_RSP_VALID);
    #1;
  endtask
  task automatic rd_chk(input space_t sp, input logic [2:0] ad);
    xfer(1'b0, sp, ad, 16'h0000);
    chk(O_RSP.rdata, (sp == SPACE_CONTROL) ? exp_q[7] : exp_q[ad]);
    chk({15'h0000, O_RSP.word_cycle}, {15'h0000, sp == SPACE_DATA});
  endtask
  initial forever #2.5 I_CLK_SYS = ~I_CLK_SYS;
  initial
  begin
    repeat (20000) @(posedge I_CLK_SYS);
    error_cnt++;
    end_sim();
  end
  initial
  begin
    void'($urandom(50));
    repeat (2) @(posedge I_CLK_SYS);
    I_ARST_N <= 1'b1;
    rd_chk(SPACE_TASK_FILE, 3'h5);
    for (int i = 0; i < 30; i++)
    begin
      s = ($urandom_range(3) == 0) ? SPACE_DATA : SPACE_TASK_FILE;
      a = (s == SPACE_DATA) ? 3'h0 : 3'($urandom_range(7, 1));
      d = (i == 0) ? 16'hFFFF : 16'($urandom);
      xfer(1'b1, s, a, d);
      exp_q[a] = lane(s, d);
      s = ($urandom_range(2) == 0) ? SPACE_DATA : SPACE_TASK_FILE;
      rd_chk(s, (s == SPACE_DATA) ? 3'h0 : 3'($urandom_range(7, 1)));
    end
    xfer(1'b1, SPACE_CONTROL, 3'h6, 16'h00FF);
    rd_chk(SPACE_TASK_FILE, 3'h6);
    rd_chk(SPACE_CONTROL, 3'h6);
    @(posedge I_CLK_SYS);
    I_DEV_RESET <= 1'b1;
    irq <= 1'b1;
    I_DIAG_PASS <= 1'b1;
    @(posedge I_CLK_SYS);
    I_DEV_RESET <= 1'b0;
    exp_q = '{default: 16'h0000};
    repeat (5) @(posedge I_CLK_SYS);
    chk({15'h0000, I_PASS_DIAG_N}, 16'h0000);
    chk({15'h0000, O_RESET_N}, 16'h0000);
    chk({15'h0000, O_DEVICE_BUSY}, 16'h0000);
    irq <= 1'b0;
    rd_chk(SPACE_DATA, 3'h0);
    xfer(1'b0, SPACE_TASK_FILE, 3'h1, 16'h0000);
    chk({15'h0000, O_IRQ}, 16'h0000);
    irq <= 1'b1;
    repeat (6) @(posedge I_CLK_SYS);
    chk({15'h0000, O_IRQ}, 16'h0001);
    end_sim();
  end
endmodule
